// ==== include/lic_pkg.sv ====
// Constants, register map and types of the lamp illumination control block.
// Assumes a 200 MHz hclk and a single AHB-Lite slave port for software.
package lic_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_DUTY    = 8'h04;
    localparam logic [7:0] ADDR_STATUS  = 8'h08;
    localparam logic [7:0] ADDR_RESULT  = 8'h0c;
    // Control register fields
    localparam int CTRL_SW_EN      = 0;
    localparam int CTRL_SEQ_RUN    = 1;
    localparam int CTRL_CFG_LOADED = 2;
    localparam int CTRL_GPIO_MODE  = 3;
    localparam int CTRL_PIN_VAL    = 4;
    localparam int CTRL_GPIO_OE    = 5;
    localparam int CTRL_ADC_START  = 6;
    localparam int CTRL_LAMP_LSB   = 8;
    localparam int CTRL_W          = 10;
    localparam logic [9:0]  CTRL_RESET = 10'h000;
    localparam logic [23:0] DUTY_RESET = 24'h000000;
    // Duty register fields, eight bits per colour
    localparam int DUTY_RED_LSB    = 0;
    localparam int DUTY_GREEN_LSB  = 8;
    localparam int DUTY_BLUE_LSB   = 16;
    // Status register fields
    localparam int ST_MASTER       = 0;
    localparam int ST_CODE_LSB     = 1;
    localparam int ST_BUSY         = 3;
    localparam int ST_DONE         = 4;
    localparam int ST_PERMIT       = 5;
    localparam int ST_PARK_N       = 6;
    localparam int ST_GPIO_IN      = 7;
    localparam int ST_CMP          = 8;
    // Lamp select codes
    localparam logic [1:0] LAMP_NONE  = 2'h0;
    localparam logic [1:0] LAMP_RED   = 2'h1;
    localparam logic [1:0] LAMP_GREEN = 2'h2;
    localparam logic [1:0] LAMP_BLUE  = 2'h3;
    // Timing
    localparam int CLK_MHZ         = 200;
    localparam int START_DELAY_MS  = 100;
    localparam int START_DELAY_CYC = START_DELAY_MS * 1000 * CLK_MHZ;
    localparam int ADC_SETTLE_US   = 20;
    localparam int ADC_SETTLE_CYC  = ADC_SETTLE_US * CLK_MHZ;
    localparam logic [11:0] SETTLE_LAST = 12'(ADC_SETTLE_CYC - 1);
    // Conversion sequencer states
    typedef enum logic [1:0] {ADC_IDLE, ADC_SETTLE, ADC_DECIDE} lic_adc_state_t;
endpackage

// ==== design/lic_top.sv ====
// Lamp driver gating, colour current PWMs and light-sensor SAR converter.
// Assumes one 200 MHz clock, asynchronous pins on the lamp and sensor side, AHB-Lite master.
//
// The register offsets and the AHB-Lite register port were chosen for this implementation.
`default_nettype none
module lic_top
    import lic_pkg::*;
#(
    parameter int unsigned START_DELAY_CYCLES = START_DELAY_CYC
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        illumination_permit_in,
    input  wire logic        mirror_park_n_in,
    output logic             driver_master_on,
    output logic      [1:0]  lamp_select_code,
    output logic             red_lamp_en,
    output logic             green_lamp_en,
    output logic             blue_lamp_en,
    output logic             red_lamp_oe,
    output logic             green_lamp_oe,
    output logic             blue_lamp_oe,
    output logic             red_current_pwm,
    output logic             green_current_pwm,
    output logic             blue_current_pwm,
    input  wire logic        comparator_result_in,
    output logic             comparator_reference_pwm,
    input  wire logic        sensor_power_gpio_in,
    output logic             sensor_power_gpio_out,
    output logic             sensor_power_gpio_oe
);
    // Lamp code to one-hot {blue, green, red} enables
    function automatic logic [2:0] lamp_decode(input logic [1:0] code);
        logic [2:0] en;
        en = 3'h0;
        case (code)
            LAMP_RED:   en = 3'h1;
            LAMP_GREEN: en = 3'h2;
            LAMP_BLUE:  en = 3'h4;
            default:    en = 3'h0;
        endcase
        return en;
    endfunction

    localparam int NSYNC = 4;
    logic [NSYNC-1:0] pin_raw;              // Asynchronous pins
    logic [NSYNC-1:0] s1_reg, s2_reg, s3_reg; // Three-stage synchronisers
    logic [NSYNC-1:0] filt_reg;             // Filtered, accepted levels
    logic             permit_f, park_n_f, cmp_f, gpio_in_f;

    assign pin_raw = {sensor_power_gpio_in, comparator_result_in, mirror_park_n_in, illumination_permit_in};

    // A new level counts only once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    s1_reg[gi]   <= 1'b0;
                    s2_reg[gi]   <= 1'b0;
                    s3_reg[gi]   <= 1'b0;
                    filt_reg[gi] <= 1'b0;
                end else begin
                    s1_reg[gi] <= pin_raw[gi];
                    s2_reg[gi] <= s1_reg[gi];
                    s3_reg[gi] <= s2_reg[gi];
                    if (s2_reg[gi] == s3_reg[gi]) begin
                        filt_reg[gi] <= s3_reg[gi];
                    end
                end
            end
        end
    endgenerate

    assign permit_f  = filt_reg[0];
    assign park_n_f  = filt_reg[1];
    assign cmp_f     = filt_reg[2];
    assign gpio_in_f = filt_reg[3];

    // Software registers
    logic [CTRL_W-1:0] ctrl_reg;            // Control bits
    logic [23:0]       duty_reg;            // Colour duty values
    logic [7:0]        result_reg;          // Last conversion result
    logic              done_reg;            // Conversion finished
    logic              wr_pend_reg;         // Write data phase pending
    logic [7:0]        wr_addr_reg;         // Latched write address
    logic              addr_ok;             // Valid address phase
    logic              start_pulse;         // Conversion start request

    assign addr_ok     = hsel && hready && htrans[1];
    assign start_pulse = wr_pend_reg && (wr_addr_reg == ADDR_CTRL) && hwdata[CTRL_ADC_START];

    // Address phase capture; a single zero-wait slave, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
        end else begin
            wr_pend_reg <= addr_ok && hwrite;
            wr_addr_reg <= haddr[7:0];
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
        end
    end

    // Register writes land in the data phase; start bit is a trigger, never stored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= CTRL_RESET;
            duty_reg <= DUTY_RESET;
        end else if (wr_pend_reg) begin
            case (wr_addr_reg)
                ADDR_CTRL: ctrl_reg <= hwdata[CTRL_W-1:0] & ~(CTRL_W'(1) << CTRL_ADC_START);
                ADDR_DUTY: duty_reg <= hwdata[23:0];
                default:   ;
            endcase
        end
    end

    // Start delay counter, held at zero while permit is low
    logic [24:0] delay_cnt_reg;
    logic        delay_done;
    assign delay_done = (32'(delay_cnt_reg) >= START_DELAY_CYCLES);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            delay_cnt_reg <= 25'h0000000;
        end else if (!permit_f) begin
            delay_cnt_reg <= 25'h0000000;
        end else if (!delay_done) begin
            delay_cnt_reg <= delay_cnt_reg + 25'h0000001;
        end
    end

    // Master enable and lamp code; the code register stands in for sequence timing
    logic       master_next;
    logic [1:0] code_next;
    logic [2:0] en_next;
    assign master_next = permit_f && park_n_f && delay_done;
    assign code_next   = (permit_f && delay_done) ? ctrl_reg[CTRL_LAMP_LSB +: 2] : LAMP_NONE;
    assign en_next     = master_next ? lamp_decode(code_next) : 3'h0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            driver_master_on <= 1'b0;
            lamp_select_code <= LAMP_NONE;
            red_lamp_en      <= 1'b0;
            green_lamp_en    <= 1'b0;
            blue_lamp_en     <= 1'b0;
        end else begin
            driver_master_on <= master_next;
            lamp_select_code <= code_next;
            red_lamp_en      <= en_next[0];
            green_lamp_en    <= en_next[1];
            blue_lamp_en     <= en_next[2];
        end
    end

    // Lamp enable pins stay undriven until configuration is marked loaded
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            red_lamp_oe   <= 1'b0;
            green_lamp_oe <= 1'b0;
            blue_lamp_oe  <= 1'b0;
        end else begin
            red_lamp_oe   <= ctrl_reg[CTRL_CFG_LOADED];
            green_lamp_oe <= ctrl_reg[CTRL_CFG_LOADED];
            blue_lamp_oe  <= ctrl_reg[CTRL_CFG_LOADED];
        end
    end

    // Shared 8-bit PWM period of 256 cycles
    logic [7:0] pwm_cnt_reg;
    logic       pwm_force;
    assign pwm_force = !driver_master_on || !ctrl_reg[CTRL_SW_EN] || !ctrl_reg[CTRL_SEQ_RUN];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwm_cnt_reg       <= 8'h00;
            red_current_pwm   <= 1'b1;
            green_current_pwm <= 1'b1;
            blue_current_pwm  <= 1'b1;
        end else begin
            pwm_cnt_reg       <= pwm_cnt_reg + 8'h01;
            red_current_pwm   <= pwm_force || (pwm_cnt_reg < duty_reg[DUTY_RED_LSB +: 8]);
            green_current_pwm <= pwm_force || (pwm_cnt_reg < duty_reg[DUTY_GREEN_LSB +: 8]);
            blue_current_pwm  <= pwm_force || (pwm_cnt_reg < duty_reg[DUTY_BLUE_LSB +: 8]);
        end
    end

    // SAR sequencer: trial bit set, settle, then keep or clear on the comparator
    lic_adc_state_t adc_state_reg;
    logic [7:0]     sar_reg;                // Trial value driving the reference
    logic [2:0]     bit_idx_reg;            // Bit under trial
    logic [11:0]    settle_cnt_reg;         // Settling counter

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            adc_state_reg  <= ADC_IDLE;
            sar_reg        <= 8'h00;
            bit_idx_reg    <= 3'h7;
            settle_cnt_reg <= 12'h000;
            result_reg     <= 8'h00;
            done_reg       <= 1'b0;
        end else begin
            case (adc_state_reg)
                ADC_IDLE: begin
                    if (start_pulse) begin
                        sar_reg        <= 8'h80;
                        bit_idx_reg    <= 3'h7;
                        settle_cnt_reg <= 12'h000;
                        done_reg       <= 1'b0;
                        adc_state_reg  <= ADC_SETTLE;
                    end
                end
                ADC_SETTLE: begin
                    // Reference filter and comparator need time before the decision
                    settle_cnt_reg <= settle_cnt_reg + 12'h001;
                    if (settle_cnt_reg == SETTLE_LAST) begin
                        adc_state_reg <= ADC_DECIDE;
                    end
                end
                ADC_DECIDE: begin
                    // High comparator means sensor above reference: keep the bit
                    sar_reg[bit_idx_reg] <= cmp_f;
                    settle_cnt_reg       <= 12'h000;
                    if (bit_idx_reg == 3'h0) begin
                        result_reg    <= {sar_reg[7:1], cmp_f};
                        done_reg      <= 1'b1;
                        adc_state_reg <= ADC_IDLE;
                    end else begin
                        sar_reg[bit_idx_reg - 3'h1] <= 1'b1;
                        bit_idx_reg   <= bit_idx_reg - 3'h1;
                        adc_state_reg <= ADC_SETTLE;
                    end
                end
                default: adc_state_reg <= ADC_IDLE;
            endcase
        end
    end

    // Reference PWM follows the trial value, idles low outside conversions
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            comparator_reference_pwm <= 1'b0;
        end else begin
            comparator_reference_pwm <= (adc_state_reg != ADC_IDLE) && (pwm_cnt_reg < sar_reg);
        end
    end

    // Shared pin: sensor power output, or general purpose under software control
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sensor_power_gpio_out <= 1'b0;
            sensor_power_gpio_oe  <= 1'b0;
        end else begin
            sensor_power_gpio_out <= ctrl_reg[CTRL_PIN_VAL];
            sensor_power_gpio_oe  <= ctrl_reg[CTRL_GPIO_MODE] ? ctrl_reg[CTRL_GPIO_OE] : 1'b1;
        end
    end

    // Read data is prepared in the address phase so it stands from a flop in the data phase
    logic [31:0] status_word;
    assign status_word = {23'h000000, cmp_f, gpio_in_f, park_n_f, permit_f, done_reg,
                          (adc_state_reg != ADC_IDLE), lamp_select_code, driver_master_on};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (addr_ok && !hwrite) begin
            case (haddr[7:0])
                ADDR_CTRL:   hrdata <= {22'h000000, ctrl_reg};
                ADDR_DUTY:   hrdata <= {8'h00, duty_reg};
                ADDR_STATUS: hrdata <= status_word;
                ADDR_RESULT: hrdata <= {24'h000000, result_reg};
                default:     hrdata <= 32'h00000000;
            endcase
        end
    end

    // Checks
    sequence s_decide_low;
        adc_state_reg == ADC_DECIDE && !cmp_f;
    endsequence

    property p_master_drop;
        @(posedge hclk) disable iff (!hresetn) (!permit_f || !park_n_f) |=> !driver_master_on;
    endproperty
    a_master_drop: assert property (p_master_drop) else $error("master enable not dropped");

    property p_code_forced;
        @(posedge hclk) disable iff (!hresetn) !permit_f |=> (lamp_select_code == LAMP_NONE) && !driver_master_on;
    endproperty
    a_code_forced: assert property (p_code_forced) else $error("lamp code not forced to none");

    property p_start_delay;
        @(posedge hclk) disable iff (!hresetn) $rose(driver_master_on) |-> $past(delay_done) && $past(permit_f);
    endproperty
    a_start_delay: assert property (p_start_delay) else $error("master enable before start delay");

    property p_delay_clear;
        @(posedge hclk) disable iff (!hresetn) !permit_f |=> delay_cnt_reg == 25'h0000000;
    endproperty
    a_delay_clear: assert property (p_delay_clear) else $error("delay counter not cleared");

    property p_pwm_forced;
        @(posedge hclk) disable iff (!hresetn) pwm_force |=> red_current_pwm && green_current_pwm && blue_current_pwm;
    endproperty
    a_pwm_forced: assert property (p_pwm_forced) else $error("current PWM not forced high");

    property p_lamp_oe;
        @(posedge hclk) disable iff (!hresetn)
            !ctrl_reg[CTRL_CFG_LOADED] |=> !red_lamp_oe && !green_lamp_oe && !blue_lamp_oe;
    endproperty
    a_lamp_oe: assert property (p_lamp_oe) else $error("lamp enable driven before load");

    property p_lamp_decode;
        @(posedge hclk) disable iff (!hresetn)
            {blue_lamp_en, green_lamp_en, red_lamp_en} == (driver_master_on ? lamp_decode(lamp_select_code) : 3'h0);
    endproperty
    a_lamp_decode: assert property (p_lamp_decode) else $error("lamp enables disagree with code");

    property p_sar_decide;
        @(posedge hclk) disable iff (!hresetn) s_decide_low |=> !sar_reg[$past(bit_idx_reg)];
    endproperty
    a_sar_decide: assert property (p_sar_decide) else $error("trial bit kept on low comparator");

    property p_ref_pwm;
        @(posedge hclk) disable iff (!hresetn)
            (adc_state_reg == ADC_SETTLE) |=> comparator_reference_pwm == ($past(pwm_cnt_reg) < $past(sar_reg));
    endproperty
    a_ref_pwm: assert property (p_ref_pwm) else $error("reference PWM wrong");

    property p_pin_power;
        @(posedge hclk) disable iff (!hresetn)
            !ctrl_reg[CTRL_GPIO_MODE] |=> sensor_power_gpio_oe &&
                (sensor_power_gpio_out == $past(ctrl_reg[CTRL_PIN_VAL]));
    endproperty
    a_pin_power: assert property (p_pin_power) else $error("sensor power pin not driven");
endmodule
`default_nettype wire

// ==== testbench/lic_partner.sv ====
// Far-side model: lamp driver decode with pull-downs, light-sensor comparator.
// Assumes the reference PWM repeats every 256 clocks and the sensor level is held by the bench.
`default_nettype none
module lic_partner (
    input  wire logic       hclk,
    input  wire logic [7:0] sensor_level,
    input  wire logic       comparator_reference_pwm,
    output logic            comparator_result_in,
    input  wire logic       driver_master_on,
    input  wire logic [1:0] lamp_select_code,
    input  wire logic [2:0] lamp_en,
    input  wire logic [2:0] lamp_oe,
    output logic      [2:0] lamp_pin,
    output logic      [2:0] lamp_lit
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [255:0] ref_hist = '0; // Last period of reference samples, stands in for the RC filter
    logic [3:0]   onehot;        // Decoded code, bit 0 means no lamp
    // Filter the reference over one whole PWM period
    always @(posedge hclk) begin
        ref_hist <= {ref_hist[254:0], comparator_reference_pwm};
    end
    // Sensor sits half a step above its code, so a trial at or below it reads high
    always_comb begin
        comparator_result_in = ($countones(ref_hist) <= int'(sensor_level));
    end
    // Undriven lamp pins fall to the board pull-downs
    assign lamp_pin = lamp_oe & lamp_en;
    // External decode of the select code into at most one lit lamp
    assign onehot = 4'h1 << lamp_select_code;
    assign lamp_lit = driver_master_on ? onehot[3:1] : 3'h0;
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench for the lamp illumination block beside its far-side model.
// Assumes a shortened start delay so permit scenarios stay a few hundred clocks long.
`default_nettype none
module testbench;
    import lic_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int          DLY  = 50;     // Shortened start delay in clocks
    localparam logic [31:0] BASE = 32'h17; // Lamps allowed, running, loaded, sensor powered
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        permit = 1'b0;
    logic        park_n = 1'b1;
    logic        gpio_drive = 1'b0;    // Board level on the shared pin when released
    logic [7:0]  sensor_level = 8'h00; // Light level seen by the comparator
    logic        master_on, ref_pwm, cmp, gpio_out, gpio_oe;
    logic [1:0]  code;
    logic [2:0]  en, oe, pwm, lamp_pin, lit;
    wire logic   gpio_in;
    int          bad_count = 0;
    int          num_checks = 0;
    // Shared pin resolves to whoever drives it
    assign gpio_in = gpio_oe ? gpio_out : gpio_drive;
    always #2.5 hclk = ~hclk;
    lic_top #(.START_DELAY_CYCLES(DLY)) lic_top_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .illumination_permit_in(permit), .mirror_park_n_in(park_n),
        .driver_master_on(master_on), .lamp_select_code(code), .red_lamp_en(en[0]), .green_lamp_en(en[1]),
        .blue_lamp_en(en[2]), .red_lamp_oe(oe[0]), .green_lamp_oe(oe[1]), .blue_lamp_oe(oe[2]),
        .red_current_pwm(pwm[0]), .green_current_pwm(pwm[1]), .blue_current_pwm(pwm[2]),
        .comparator_result_in(cmp), .comparator_reference_pwm(ref_pwm), .sensor_power_gpio_in(gpio_in),
        .sensor_power_gpio_out(gpio_out), .sensor_power_gpio_oe(gpio_oe));
    lic_partner lic_partner_inst (
        .hclk(hclk), .sensor_level(sensor_level), .comparator_reference_pwm(ref_pwm),
        .comparator_result_in(cmp), .driver_master_on(master_on), .lamp_select_code(code),
        .lamp_en(en), .lamp_oe(oe), .lamp_pin(lamp_pin), .lamp_lit(lit));
    // Compare and count; an unknown never matches
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One single AHB transfer; waits on hready with no assumed latency
    task automatic ahb_xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                            output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb_xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] q);
        ahb_xfer(1'b0, a, 32'h0, q);
    endtask
    // Clocks until the master enable shows the level, capped so a hang cannot stall here
    task automatic wait_on(input logic lvl, output int n);
        n = 0;
        while (master_on !== lvl && n < 200) begin
            @(posedge hclk);
            n++;
        end
    endtask
    // High clocks of each PWM over one full period, after a short settling gap
    task automatic count_high(output int c[4]);
        c = '{default: 0};
        repeat (4) @(posedge hclk);
        repeat (256) begin
            @(posedge hclk);
            for (int i = 0; i < 3; i++) c[i] += int'(pwm[i]);
            c[3] += int'(ref_pwm);
        end
    endtask
    // Reset values at the pins and in the control register, and an unmapped read
    task automatic t_reset();
        logic [31:0] q;
        chk("master", 32'h0, master_on);
        chk("code", 32'h0, code);
        chk("lamp oe", 32'h0, oe);
        chk("lamp pins", 32'h0, lamp_pin);
        chk("current pwm", 32'h7, pwm);
        chk("hresp", 32'h0, hresp);
        chk("hreadyout", 32'h1, hreadyout);
        rd(32'(ADDR_CTRL), q);
        chk("ctrl", 32'h0, q);
        rd(32'h10, q);
        chk("unmapped", 32'h0, q);
    endtask
    // Permit rise waits the delay, then codes 1 to 3 each decode to one lamp and code 0 to none
    task automatic t_permit();
        int n;
        logic [31:0] q;
        wr(32'(ADDR_CTRL), BASE | 32'h300);
        permit <= 1'b1;
        repeat (30) @(posedge hclk);
        chk("master early", 32'h0, master_on);
        chk("code held", 32'h0, code);
        wait_on(1'b1, n);
        chk("start delay", 32'h1, 32'(n + 30 >= DLY && n + 30 <= DLY + 8));
        for (int c = 0; c < 4; c++) begin
            wr(32'(ADDR_CTRL), BASE | (32'(c) << 8));
            repeat (3) @(posedge hclk);
            chk("code", 32'(c), code);
            chk("lamp pins", (32'h1 << c) >> 1, lamp_pin);
            chk("lamp lit", (32'h1 << c) >> 1, lit);
        end
        // Comparator high, pin powered, park released, permit, blue code, master on
        rd(32'(ADDR_STATUS), q);
        chk("status", 32'h1e7, q);
    endtask
    // Duty per colour, then forced high when software control or sequence stops
    task automatic t_pwm();
        int c[4];
        wr(32'(ADDR_DUTY), 32'h00ff0040);
        wr(32'(ADDR_CTRL), BASE | 32'h100);
        count_high(c);
        chk("red duty", 32'h40, c[0]);
        chk("green duty", 32'h0, c[1]);
        chk("blue duty", 32'hff, c[2]);
        for (int k = 0; k < 2; k++) begin
            wr(32'(ADDR_CTRL), (BASE | 32'h100) & ~(32'h1 << k));
            count_high(c);
            chk("pwm forced", 32'd768, c[0] + c[1] + c[2]);
        end
        wr(32'(ADDR_CTRL), BASE | 32'h100);
    endtask
    // Permit drop, a short permit glitch that must restart the delay, then park
    task automatic t_drop();
        int c[4];
        int n;
        permit <= 1'b0;
        wait_on(1'b0, n);
        chk("permit drop", 32'h1, 32'(n <= 6));
        repeat (3) @(posedge hclk);
        chk("code forced", 32'h0, code);
        count_high(c);
        chk("pwm off", 32'd768, c[0] + c[1] + c[2]);
        permit <= 1'b1;
        repeat (30) @(posedge hclk);
        permit <= 1'b0;
        repeat (4) @(posedge hclk);
        permit <= 1'b1;
        repeat (45) @(posedge hclk);
        chk("delay restarted", 32'h0, master_on);
        wait_on(1'b1, n);
        chk("master back", 32'h1, master_on);
        park_n <= 1'b0;
        wait_on(1'b0, n);
        chk("park drop", 32'h1, 32'(n <= 6));
        park_n <= 1'b1;
    endtask
    // One conversion against a held sensor level
    task automatic t_adc(input logic [7:0] lvl);
        int c[4];
        int n;
        logic [31:0] q;
        sensor_level <= lvl;
        wr(32'(ADDR_CTRL), BASE | 32'h40);
        count_high(c);
        chk("first trial duty", 32'd128, c[3]);
        rd(32'(ADDR_STATUS), q);
        chk("busy", 32'h1, q[ST_BUSY]);
        n = 0;
        do begin
            rd(32'(ADDR_STATUS), q);
            n++;
        end while (q[ST_BUSY] !== 1'b0 && n < 40000);
        chk("done", 32'h1, q[ST_DONE]);
        rd(32'(ADDR_RESULT), q);
        chk("result", {24'h0, lvl}, q);
    endtask
    // Shared pin as sensor power, as input, then as driven output
    task automatic t_gpio();
        logic [31:0] q;
        wr(32'(ADDR_CTRL), 32'h10);
        repeat (2) @(posedge hclk);
        chk("power pin", 32'h3, {gpio_oe, gpio_out});
        gpio_drive <= 1'b1;
        wr(32'(ADDR_CTRL), 32'h08);
        repeat (6) @(posedge hclk);
        chk("pin released", 32'h0, gpio_oe);
        rd(32'(ADDR_STATUS), q);
        chk("pin input", 32'h1, q[ST_GPIO_IN]);
        wr(32'(ADDR_CTRL), 32'h28);
        repeat (2) @(posedge hclk);
        chk("pin output", 32'h2, {gpio_oe, gpio_out});
    endtask
    // Verdict and end of run
    task automatic final_report();
        if (bad_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_permit();
        t_pwm();
        t_drop();
        t_adc(8'ha5);
        t_adc(8'h3c);
        t_gpio();
        final_report();
    end
    // Watchdog well beyond two conversions and the lamp scenarios
    initial begin
        #450000;
        bad_count++;
        final_report();
    end
endmodule
`default_nettype wire
